// >>> design/rtw_watchdog_ctl.sv
`timescale 1ns/1ps
// Behaviour
// - Reading flag register clears three flags
// - Read clear acts at access end, address stable
// - Interrupt pin releases once pending flag clears
// - Writing zero clears alarm or timeout flag
// - Clock advance bit gates per-second update
// - Clock advance bit changed only by host
// - Crystal load select drives oscillator load
// - Auto-increment steps RAM address per access
// - Alarm flag with power enable drives power
// - Alarm interrupt enable gates pending flag
// - Key pulse without supply wakes, flags, only with key enable set
// - Key flag with enable drives power pin, and interrupt pin with main supply
// - Power-on reset clears arm and steer
// - Timeout from two BCD period registers
// - Every timeout reloads and sets timeout flag
// - Repetitive mode raises interrupt on timeout
// - Host period write reloads the counter
// - Single-shot mode pulses reset, clears arm
// - Both period bytes zero disables watchdog
// - Oscillator runs only while stop bit clear
// - Pending flag is OR of enabled flags
// - Flag bit positions three down to zero
// - Enabled wake event clears power release bit
module rtw_watchdog_ctl
	import rtw_pkg::*;
#(
	parameter int RST_PULSE_CYCLES = RESET_PULSE_CYCLES
)
(
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,
	input  wire logic [4:0] i_addr,
	input  wire logic [7:0] i_data,
	input  wire logic       i_cs_n,
	input  wire logic       i_oe_n,
	input  wire logic       i_we_n,
	output logic      [7:0] o_data,
	output logic            o_data_oe,
	input  wire logic       i_osc_tick,
	input  wire logic       i_oscillator_stop,
	input  wire logic       i_alarm_match,
	input  wire logic       i_wake_key_in_n,
	input  wire logic       i_main_supply,
	input  wire logic [1:0] i_batt_low,
	input  wire logic [7:0] i_ram_data,
	output logic            o_irq_n_out,
	output logic            o_irq_n_oe,
	output logic            o_power_on_out_n_out,
	output logic            o_power_on_out_n_oe,
	output logic            o_rst_n,
	output logic            o_osc_run,
	output logic            o_crystal_load_12p5,
	output logic            o_clock_advance_on,
	output logic            o_update_tick,
	output logic      [7:0] o_ram_addr,
	output logic            o_ram_wr,
	output logic      [7:0] o_ram_wdata
);
	typedef struct packed {
		logic [7:0]  wdt_a;
		logic [7:0]  wdt_b;
		logic [7:0]  ctrl;
		logic [7:0]  ram_addr;
		logic        alarm_match_flag;
		logic        wake_key_flag;
		logic        timeout_flag;
		logic        power_release;
		logic        hold_in_fail;
		logic        reload;
		logic [23:0] rst_cnt;
		logic        rd_prev;
		logic [4:0]  rd_addr;
		logic [1:0]  rd_stable;
		logic        wr_prev;
		logic [4:0]  wr_addr;
		logic [7:0]  wr_data;
		logic        key_prev;
		logic [7:0]  rdata;
		logic        irq_drive;
		logic        pwr_drive;
		logic        update_tick;
		logic        ram_wr;
		logic [7:0]  ram_wdata;
	} rtw_ctl_t;

	rtw_ctl_t st;
	rtw_ctl_t next_st;

	rtw_tick_if tick ();

	logic       rd_active;
	logic       wr_active;
	logic       rd_end;
	logic       flags_clear;
	logic       wr_commit;
	logic       key_fall;

	// Pending flag as a pure function of flags and enables
	function automatic logic rtw_pending(input logic [7:0] ctrl, input logic alarm,
		input logic key, input logic tmo);
		return (alarm & ctrl[CTRL_ALARM_IRQ]) | (key & ctrl[CTRL_WAKE_KEY]) |
			(tmo & ctrl[CTRL_WDT_ARM]);
	endfunction

	// Readback of the mapped bytes; unmapped addresses read zero
	function automatic logic [7:0] rtw_read(input logic [4:0] a, input rtw_ctl_t s,
		input logic [1:0] batt, input logic [7:0] ram);
		logic [7:0] f;
		f = 8'h00;
		f[FLAG_BATT_MAIN] = batt[1];
		f[FLAG_BATT_AUX] = batt[0];
		f[FLAG_HOLD_IN_FAIL] = s.hold_in_fail;
		f[FLAG_POWER_RELEASE] = s.power_release;
		f[FLAG_ALARM] = s.alarm_match_flag;
		f[FLAG_WAKE_KEY] = s.wake_key_flag;
		f[FLAG_TIMEOUT] = s.timeout_flag;
		f[FLAG_IRQ] = rtw_pending(s.ctrl, s.alarm_match_flag, s.wake_key_flag,
			s.timeout_flag);
		unique case (a)
			ADDR_WDT_A:    return s.wdt_a;
			ADDR_WDT_B:    return s.wdt_b;
			ADDR_FLAGS:    return f;
			ADDR_CTRL:     return s.ctrl;
			ADDR_RAM_ADDR: return s.ram_addr;
			ADDR_RAM_DATA: return ram;
			default:       return 8'h00;
		endcase
	endfunction

	// Host port decode
	assign rd_active = !i_cs_n && !i_oe_n && i_we_n;
	assign wr_active = !i_cs_n && !i_we_n;
	// Access ends on address change or a rising select or output enable
	assign rd_end = st.rd_prev && (!rd_active || i_addr != st.rd_addr);
	assign flags_clear = rd_end && st.rd_addr == ADDR_FLAGS &&
		st.rd_stable >= ADDR_STABLE_CYCLES;
	// Writes commit at their trailing edge, when data has settled
	assign wr_commit = st.wr_prev && !wr_active;
	assign key_fall = st.key_prev && !i_wake_key_in_n;

	// Oscillator gating stops every derived tick as well
	assign o_osc_run = !i_oscillator_stop;
	assign tick.osc_tick = i_osc_tick && !i_oscillator_stop;
	assign tick.reload = st.reload;
	assign tick.period = {st.wdt_b, st.wdt_a};

	always_comb
	begin
		next_st = st;
		next_st.reload = 1'b0;
		next_st.ram_wr = 1'b0;

		// Read tracking: count cycles the address has been held
		next_st.rd_prev = rd_active;
		next_st.rd_addr = i_addr;
		if (rd_active && st.rd_prev && i_addr == st.rd_addr)
		begin
			if (st.rd_stable < ADDR_STABLE_CYCLES)
				next_st.rd_stable = st.rd_stable + 2'h1;
		end
		else
		begin
			next_st.rd_stable = 2'h0;
		end

		// Write capture while the strobe is low
		next_st.wr_prev = wr_active;
		if (wr_active)
		begin
			next_st.wr_addr = i_addr;
			next_st.wr_data = i_data;
		end

		// Clears by read go first so that same-cycle events survive
		if (flags_clear)
		begin
			next_st.alarm_match_flag = 1'b0;
			next_st.wake_key_flag = 1'b0;
			next_st.timeout_flag = 1'b0;
		end

		// Burst stepping on a finished data read
		if (rd_end && st.rd_addr == ADDR_RAM_DATA && st.ctrl[CTRL_RAM_AUTO_INC])
			next_st.ram_addr = st.ram_addr + 8'h01;

		if (wr_commit)
		begin
			unique case (st.wr_addr)
				ADDR_WDT_A:
				begin
					next_st.wdt_a = st.wr_data;
					next_st.reload = 1'b1;
				end
				ADDR_WDT_B:
				begin
					next_st.wdt_b = st.wr_data;
					next_st.reload = 1'b1;
				end
				ADDR_FLAGS:
				begin
					next_st.hold_in_fail = st.wr_data[FLAG_HOLD_IN_FAIL];
					next_st.power_release = st.wr_data[FLAG_POWER_RELEASE];
					if (!st.wr_data[FLAG_ALARM])
						next_st.alarm_match_flag = 1'b0;
					if (!st.wr_data[FLAG_TIMEOUT])
						next_st.timeout_flag = 1'b0;
					next_st.wake_key_flag = st.wr_data[FLAG_WAKE_KEY];
				end
				ADDR_CTRL:
					next_st.ctrl = st.wr_data;
				ADDR_RAM_ADDR:
					next_st.ram_addr = st.wr_data;
				ADDR_RAM_DATA:
				begin
					next_st.ram_wr = 1'b1;
					next_st.ram_wdata = st.wr_data;
					if (st.ctrl[CTRL_RAM_AUTO_INC])
						next_st.ram_addr = st.ram_addr + 8'h01;
				end
				default:
				begin
				end
			endcase
		end

		// Hardware events set after all clears: set wins
		next_st.key_prev = i_wake_key_in_n;
		if (i_alarm_match)
			next_st.alarm_match_flag = 1'b1;
		if (key_fall && (i_main_supply || st.ctrl[CTRL_WAKE_KEY]))
			next_st.wake_key_flag = 1'b1;
		if (tick.timeout)
			next_st.timeout_flag = 1'b1;

		// Single-shot: start the reset pulse once per timeout
		if (st.rst_cnt != 24'h0)
		begin
			next_st.rst_cnt = st.rst_cnt - 24'h1;
			if (st.rst_cnt == 24'h1)
				next_st.ctrl[CTRL_WDT_ARM] = 1'b0;
		end
		else if (tick.timeout && st.ctrl[CTRL_WDT_ARM] && st.ctrl[CTRL_WDT_STEER])
		begin
			next_st.rst_cnt = 24'(RST_PULSE_CYCLES);
		end

		// An enabled wake event takes power release back
		if ((next_st.alarm_match_flag && next_st.ctrl[CTRL_ALARM_POWER]) ||
			(next_st.wake_key_flag && next_st.ctrl[CTRL_WAKE_KEY]))
			next_st.power_release = 1'b0;

		// Pins follow the updated flags in the same cycle as the flags
		next_st.irq_drive = i_main_supply && rtw_pending(next_st.ctrl,
			next_st.alarm_match_flag, next_st.wake_key_flag,
			next_st.timeout_flag);
		next_st.pwr_drive = (next_st.alarm_match_flag && next_st.ctrl[CTRL_ALARM_POWER]) ||
			(next_st.wake_key_flag && next_st.ctrl[CTRL_WAKE_KEY]) ||
			(!next_st.power_release &&
			(i_main_supply || next_st.hold_in_fail));

		// Update transfers only while the clock advances
		next_st.update_tick = tick.tick_1s && st.ctrl[CTRL_CLOCK_ADVANCE];
		next_st.rdata = rtw_read(i_addr, st, i_batt_low, i_ram_data);
	end

	// Power-on reset leaves the watchdog outputs disarmed
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
			st.wdt_a <= WDT_BYTE_RESET;
			st.wdt_b <= WDT_BYTE_RESET;
			st.ram_addr <= RAM_ADDR_RESET;
			st.power_release <= POWER_RELEASE_RESET;
			st.hold_in_fail <= HOLD_IN_FAIL_RESET;
			st.key_prev <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	rtw_prescaler u_presc
	(
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.tick    (tick)
	);

	rtw_wdt_counter u_wdt
	(
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.tick    (tick)
	);

	// Open-drain pins only ever pull low
	assign o_irq_n_out          = 1'b0;
	assign o_irq_n_oe           = st.irq_drive;
	assign o_power_on_out_n_out = 1'b0;
	assign o_power_on_out_n_oe  = st.pwr_drive;
	assign o_rst_n              = (st.rst_cnt == 24'h0);
	assign o_data               = st.rdata;
	assign o_data_oe            = rd_active;
	assign o_crystal_load_12p5  = st.ctrl[CTRL_CRYSTAL_LOAD];
	assign o_clock_advance_on   = st.ctrl[CTRL_CLOCK_ADVANCE];
	assign o_update_tick        = st.update_tick;
	assign o_ram_addr           = st.ram_addr;
	assign o_ram_wr             = st.ram_wr;
	assign o_ram_wdata          = st.ram_wdata;
endmodule

// >>> design/rtw_pkg.sv
package rtw_pkg;

	// Register map of the byte-wide host port
	localparam logic [4:0] ADDR_WDT_A    = 5'h0c;
	localparam logic [4:0] ADDR_WDT_B    = 5'h0d;
	localparam logic [4:0] ADDR_FLAGS    = 5'h0e;
	localparam logic [4:0] ADDR_CTRL     = 5'h0f;
	localparam logic [4:0] ADDR_RAM_ADDR = 5'h10;
	localparam logic [4:0] ADDR_RAM_DATA = 5'h13;

	// Field positions of control_enables
	localparam int CTRL_CLOCK_ADVANCE = 7;
	localparam int CTRL_CRYSTAL_LOAD  = 6;
	localparam int CTRL_RAM_AUTO_INC  = 5;
	localparam int CTRL_ALARM_POWER   = 4;
	localparam int CTRL_ALARM_IRQ     = 3;
	localparam int CTRL_WAKE_KEY      = 2;
	localparam int CTRL_WDT_ARM       = 1;
	localparam int CTRL_WDT_STEER     = 0;

	// Field positions of the flag register
	localparam int FLAG_BATT_MAIN     = 7;
	localparam int FLAG_BATT_AUX      = 6;
	localparam int FLAG_HOLD_IN_FAIL  = 5;
	localparam int FLAG_POWER_RELEASE = 4;
	localparam int FLAG_ALARM         = 3;
	localparam int FLAG_WAKE_KEY      = 2;
	localparam int FLAG_TIMEOUT       = 1;
	localparam int FLAG_IRQ           = 0;

	// Reset values
	localparam logic [7:0]  CTRL_RESET          = 8'h00;
	localparam logic [7:0]  WDT_BYTE_RESET      = 8'h00;
	localparam logic [7:0]  RAM_ADDR_RESET      = 8'h00;
	localparam logic        POWER_RELEASE_RESET = 1'b1;
	localparam logic        HOLD_IN_FAIL_RESET  = 1'b0;

	// Host port timing
	localparam int          CLK_PERIOD_NS      = 10;
	localparam int          ADDR_STABLE_NS     = 15;
	localparam logic [1:0]  ADDR_STABLE_CYCLES =
		2'((ADDR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Reset pulse length on a single-shot timeout
	localparam int RESET_PULSE_TIME_US = 200;
	localparam int RESET_PULSE_CYCLES  = RESET_PULSE_TIME_US * 1000 / CLK_PERIOD_NS;

	// Oscillator prescaling: 10 ms tick by fractional accumulation
	localparam int           OSC_HZ      = 32768;
	localparam int           WDT_TICK_MS = 10;
	localparam logic [16:0]  PRESC_MOD   = 17'(OSC_HZ);
	localparam logic [16:0]  PRESC_STEP  = 17'(1000 / WDT_TICK_MS);
	localparam logic [14:0]  SEC_LAST    = 15'(OSC_HZ - 1);

endpackage

// >>> design/rtw_tick_if.sv
`timescale 1ns/1ps
interface rtw_tick_if;
	logic        osc_tick;
	logic        tick_10ms;
	logic        tick_1s;
	logic        reload;
	logic [15:0] period;
	logic        timeout;

	modport presc (input osc_tick, output tick_10ms, output tick_1s);
	modport wdt   (input tick_10ms, input reload, input period, output timeout);
	modport ctl   (output osc_tick, input tick_10ms, input tick_1s,
		output reload, output period, input timeout);
endinterface

// >>> design/rtw_prescaler.sv
`timescale 1ns/1ps
module rtw_prescaler
	import rtw_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_rst_b,
	rtw_tick_if.presc tick
);
	typedef struct packed {
		logic [16:0] acc;
		logic [14:0] sec;
		logic        tick_10ms;
		logic        tick_1s;
	} rtw_presc_t;

	rtw_presc_t st;
	rtw_presc_t next_st;

	// 327.68 oscillator cycles per tick; the fraction spreads as 327/328 jitter
	always_comb
	begin
		logic [16:0] sum;
		sum = 17'h0;
		next_st = st;
		next_st.tick_10ms = 1'b0;
		next_st.tick_1s = 1'b0;
		if (tick.osc_tick)
		begin
			sum = st.acc + PRESC_STEP;
			if (sum >= PRESC_MOD)
			begin
				next_st.acc = sum - PRESC_MOD;
				next_st.tick_10ms = 1'b1;
			end
			else
			begin
				next_st.acc = sum;
			end
			if (st.sec == SEC_LAST)
			begin
				next_st.sec = 15'h0;
				next_st.tick_1s = 1'b1;
			end
			else
			begin
				next_st.sec = st.sec + 15'h1;
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick.tick_10ms = st.tick_10ms;
	assign tick.tick_1s   = st.tick_1s;
endmodule

// >>> design/rtw_wdt_counter.sv
`timescale 1ns/1ps
module rtw_wdt_counter
	import rtw_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_rst_b,
	rtw_tick_if.wdt   tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        timeout;
	} rtw_wdt_t;

	rtw_wdt_t st;
	rtw_wdt_t next_st;

	// Four-digit BCD decrement, borrow ripples up through the digits
	function automatic logic [15:0] rtw_bcd_dec(input logic [15:0] v);
		logic [15:0] r;
		logic        borrow;
		r = v;
		borrow = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			if (borrow)
			begin
				if (v[i*4 +: 4] == 4'h0)
					r[i*4 +: 4] = 4'h9;
				else
				begin
					r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
					borrow = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// Host reload restarts the period; a zero period never times out
	always_comb
	begin
		next_st = st;
		next_st.timeout = 1'b0;
		if (tick.reload)
			next_st.cnt = tick.period;
		else if (tick.tick_10ms && tick.period != 16'h0)
		begin
			if (st.cnt <= 16'h0001)
			begin
				next_st.cnt = tick.period;
				next_st.timeout = 1'b1;
			end
			else
			begin
				next_st.cnt = rtw_bcd_dec(st.cnt);
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick.timeout = st.timeout;
endmodule

// >>> tb/rtw_host.sv
`timescale 1ns/1ps
module rtw_host
(
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_rd_data,
	output logic      [4:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_cs_n,
	output logic            o_oe_n,
	output logic            o_we_n
);
	// Idle bus from time zero
	initial
	begin
		o_addr = 5'h00;
		o_wdata = 8'h00;
		o_cs_n = 1'b1;
		o_oe_n = 1'b1;
		o_we_n = 1'b1;
	end

	// One strobe edge, then idle edges; released lines flip so stale data never matches
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= d;
		o_cs_n <= 1'b0;
		o_we_n <= 1'b0;
		@(posedge i_mclk);
		o_cs_n <= 1'b1;
		o_we_n <= 1'b1;
		o_wdata <= ~d;
		o_addr <= ~a;
		repeat (3) @(posedge i_mclk);
	endtask

	// Two held edges give data only; four also end a clearing read
	task automatic rd(input logic [4:0] a, input int k, output logic [7:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_cs_n <= 1'b0;
		o_oe_n <= 1'b0;
		repeat (k) @(posedge i_mclk);
		d = i_rd_data;
		o_cs_n <= 1'b1;
		o_oe_n <= 1'b1;
		o_addr <= ~a;
		repeat (3) @(posedge i_mclk);
	endtask
endmodule

// >>> tb/rtw_chk.sv
`timescale 1ns/1ps
module rtw_chk
	import rtw_pkg::*;
#(
	parameter int RST_PULSE_CYCLES = RESET_PULSE_CYCLES
)
(
	input wire logic       i_mclk,
	input wire logic       i_rst_b,
	input wire logic [4:0] i_addr,
	input wire logic       i_cs_n,
	input wire logic       i_oe_n,
	input wire logic       i_we_n,
	input wire logic       i_oscillator_stop,
	input wire logic       i_main_supply,
	input wire logic       o_irq_n_out,
	input wire logic       o_irq_n_oe,
	input wire logic       o_power_on_out_n_out,
	input wire logic       o_power_on_out_n_oe,
	input wire logic       o_rst_n,
	input wire logic       o_osc_run,
	input wire logic       o_clock_advance_on,
	input wire logic       o_update_tick,
	input wire logic       o_data_oe
);
	logic        rd;
	logic [4:0]  ctl_wr;
	logic [15:0] low_cnt;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	// Host is reading the flag register
	assign rd = !i_cs_n && !i_oe_n && i_we_n && i_addr == ADDR_FLAGS;

	// Recent control writes, and low cycles of the reset pulse
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			ctl_wr <= 5'h00;
		else
			ctl_wr <= {ctl_wr[3:0], !i_cs_n && !i_we_n && i_addr == ADDR_CTRL};
		if (!i_rst_b || o_rst_n)
			low_cnt <= 16'h0000;
		else
			low_cnt <= low_cnt + 16'h0001;
	end

	sequence s_rd2; !rd ##1 rd [*2] ##1 !rd; endsequence
	sequence s_rd4; !rd ##1 rd [*4] ##1 !rd; endsequence
	property p_rd_clear; s_rd4 |-> ##[1:2] !o_irq_n_oe; endproperty
	property p_rd_keep; s_rd2 ##0 o_irq_n_oe |=> o_irq_n_oe [*2]; endproperty
	property p_osc; o_osc_run == !i_oscillator_stop; endproperty
	property p_upd; !$past(o_clock_advance_on) |-> !o_update_tick; endproperty
	property p_adv; $changed(o_clock_advance_on) |-> |ctl_wr; endproperty
	property p_rst_len; $rose(o_rst_n) |-> low_cnt == 16'(RST_PULSE_CYCLES); endproperty
	property p_irq_supply; !$past(i_main_supply) |-> !o_irq_n_oe; endproperty
	property p_data_oe; o_data_oe == (!i_cs_n && !i_oe_n && i_we_n); endproperty
	property p_pins;
		o_irq_n_oe || o_power_on_out_n_oe |-> !o_irq_n_out && !o_power_on_out_n_out;
	endproperty

	a_rd_clear: assert property (p_rd_clear)
		else $error("flag read did not release interrupt");
	a_rd_keep: assert property (p_rd_keep)
		else $error("short read cleared interrupt");
	a_osc: assert property (p_osc)
		else $error("oscillator run wrong");
	a_upd: assert property (p_upd)
		else $error("update tick with advance off");
	a_adv: assert property (p_adv)
		else $error("advance bit changed without write");
	a_rst_len: assert property (p_rst_len)
		else $error("reset pulse length wrong");
	a_irq_supply: assert property (p_irq_supply)
		else $error("interrupt driven without supply");
	a_pins: assert property (p_pins)
		else $error("open-drain pin driven high");
	a_data_oe: assert property (p_data_oe)
		else $error("read data enable wrong");
endmodule

bind rtw_watchdog_ctl rtw_chk #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) u_rtw_chk (.i_mclk,
	.i_rst_b, .i_addr, .i_cs_n, .i_oe_n, .i_we_n, .i_oscillator_stop, .i_main_supply,
	.o_irq_n_out, .o_irq_n_oe, .o_power_on_out_n_out, .o_power_on_out_n_oe, .o_rst_n,
	.o_osc_run, .o_clock_advance_on, .o_update_tick, .o_data_oe);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
	import rtw_pkg::*;
;
	logic       i_mclk, i_rst_b, i_cs_n, i_oe_n, i_we_n, i_osc_tick, i_oscillator_stop;
	logic       i_alarm_match, i_wake_key_in_n, i_main_supply, o_data_oe, o_irq_n_out;
	logic       o_irq_n_oe, o_power_on_out_n_out, o_power_on_out_n_oe, o_rst_n, o_osc_run;
	logic       o_crystal_load_12p5, o_clock_advance_on, o_update_tick, o_ram_wr, irq_w, pwr_w;
	logic [4:0] i_addr;
	logic [7:0] i_data, o_data, o_ram_addr, o_ram_wdata, rv;
	int         failures = 0;
	int         comparisons = 0;
	int         n;
	int         ram_wrs = 0;

	// Pull-ups hold released pins high
	assign irq_w = o_irq_n_oe ? o_irq_n_out : 1'b1;
	assign pwr_w = o_power_on_out_n_oe ? o_power_on_out_n_out : 1'b1;

	rtw_watchdog_ctl #(.RST_PULSE_CYCLES(8)) u_rtw_watchdog_ctl (.i_mclk, .i_rst_b, .i_addr,
		.i_data, .i_cs_n, .i_oe_n, .i_we_n, .o_data, .o_data_oe, .i_osc_tick,
		.i_oscillator_stop, .i_alarm_match, .i_wake_key_in_n, .i_main_supply,
		.i_batt_low(2'b10), .i_ram_data(8'h5a), .o_irq_n_out, .o_irq_n_oe,
		.o_power_on_out_n_out, .o_power_on_out_n_oe, .o_rst_n, .o_osc_run,
		.o_crystal_load_12p5, .o_clock_advance_on, .o_update_tick, .o_ram_addr,
		.o_ram_wr, .o_ram_wdata);

	rtw_host u_rtw_host (.i_mclk, .i_rd_data(o_data), .o_addr(i_addr), .o_wdata(i_data),
		.o_cs_n(i_cs_n), .o_oe_n(i_oe_n), .o_we_n(i_we_n));

	initial
	begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	// Oscillator at half the bus clock, so 10 ms ticks come every ~655 cycles
	always @(posedge i_mclk) i_osc_tick <= i_rst_b ? ~i_osc_tick : 1'b0;

	// Count RAM write strobes; each stands for one cycle only
	always @(posedge i_mclk)
		if (o_ram_wr === 1'b1) ram_wrs <= ram_wrs + 1;

	task automatic cyc(input int k);
		repeat (k) @(posedge i_mclk);
	endtask
	task automatic pk(input logic [4:0] a, input logic [7:0] e);
		u_rtw_host.rd(a, 2, rv);
		`CK(rv, e)
	endtask
	task automatic cl(input logic [7:0] e);
		u_rtw_host.rd(ADDR_FLAGS, 4, rv);
		`CK(rv, e)
	endtask
	task automatic alarm();
		i_alarm_match <= 1'b1;
		cyc(1);
		i_alarm_match <= 1'b0;
		cyc(3);
	endtask
	task automatic key();
		i_wake_key_in_n <= 1'b0;
		cyc(3);
		i_wake_key_in_n <= 1'b1;
		cyc(3);
	endtask
	// Bounded wait for the interrupt pin or the reset pulse
	task automatic wt(input bit r);
		n = 0;
		while ((r ? o_rst_n : irq_w) !== 1'b0 && n < 3000)
		begin
			cyc(1);
			n++;
		end
	endtask
	task conclude;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		i_rst_b = 1'b0;
		i_oscillator_stop = 1'b0;
		i_alarm_match = 1'b0;
		i_wake_key_in_n = 1'b1;
		i_main_supply = 1'b1;
		cyc(4);
		i_rst_b <= 1'b1;
		cyc(1);
		pk(ADDR_CTRL, CTRL_RESET);
		pk(5'h1f, 8'h00);
		pk(ADDR_FLAGS, 8'h90);
		u_rtw_host.wr(ADDR_CTRL, 8'h40);
		`CK({o_crystal_load_12p5, o_clock_advance_on}, 2'b10)
		u_rtw_host.wr(ADDR_CTRL, 8'hc0);
		pk(ADDR_CTRL, 8'hc0);
		// Alarm with both enables, then with neither
		u_rtw_host.wr(ADDR_CTRL, 8'h18);
		alarm();
		`CK({irq_w, pwr_w}, 2'b00)
		cl(8'h89);
		`CK({irq_w, pwr_w}, 2'b10)
		u_rtw_host.wr(ADDR_FLAGS, 8'h10);
		`CK(pwr_w, 1'b1)
		u_rtw_host.wr(ADDR_CTRL, 8'h00);
		alarm();
		`CK({irq_w, pwr_w}, 2'b11)
		pk(ADDR_FLAGS, 8'h98);
		u_rtw_host.wr(ADDR_FLAGS, 8'h10);
		pk(ADDR_FLAGS, 8'h90);
		// A read too short to clear leaves the interrupt standing
		u_rtw_host.wr(ADDR_CTRL, 8'h08);
		alarm();
		pk(ADDR_FLAGS, 8'h99);
		`CK(irq_w, 1'b0)
		cl(8'h99);
		`CK(irq_w, 1'b1)
		// Wake key with and without its enable, supply present
		u_rtw_host.wr(ADDR_CTRL, 8'h04);
		key();
		`CK({irq_w, pwr_w}, 2'b00)
		pk(ADDR_FLAGS, 8'h85);
		u_rtw_host.wr(ADDR_FLAGS, 8'h10);
		`CK({irq_w, pwr_w}, 2'b11)
		u_rtw_host.wr(ADDR_CTRL, 8'h00);
		key();
		`CK({irq_w, pwr_w}, 2'b11)
		pk(ADDR_FLAGS, 8'h94);
		// Key wake with main supply absent
		u_rtw_host.wr(ADDR_FLAGS, 8'h10);
		u_rtw_host.wr(ADDR_CTRL, 8'h04);
		i_main_supply <= 1'b0;
		key();
		`CK({irq_w, pwr_w}, 2'b10)
		i_main_supply <= 1'b1;
		cyc(3);
		`CK(irq_w, 1'b0)
		cl(8'h85);
		u_rtw_host.wr(ADDR_FLAGS, 8'h10);
		// Repetitive watchdog, period 0.02 s; advance stays off
		u_rtw_host.wr(ADDR_CTRL, 8'h02);
		u_rtw_host.wr(ADDR_WDT_B, 8'h00);
		u_rtw_host.wr(ADDR_WDT_A, 8'h02);
		wt(0);
		`CK(n > 600 && n < 1330, 1'b1)
		cl(8'h93);
		cyc(1000);
		u_rtw_host.wr(ADDR_WDT_A, 8'h02);
		wt(0);
		`CK(n > 600 && n < 1330, 1'b1)
		cl(8'h93);
		u_rtw_host.wr(ADDR_CTRL, 8'h00);
		cyc(1400);
		`CK(irq_w, 1'b1)
		pk(ADDR_FLAGS, 8'h92);
		u_rtw_host.wr(ADDR_WDT_A, 8'h00);
		u_rtw_host.wr(ADDR_FLAGS, 8'h10);
		cyc(1500);
		pk(ADDR_FLAGS, 8'h90);
		// Single-shot watchdog
		u_rtw_host.wr(ADDR_CTRL, 8'h03);
		u_rtw_host.wr(ADDR_WDT_A, 8'h01);
		wt(1);
		`CK(o_rst_n, 1'b0)
		cyc(12);
		pk(ADDR_CTRL, 8'h01);
		pk(ADDR_FLAGS, 8'h92);
		u_rtw_host.wr(ADDR_WDT_A, 8'h00);
		// RAM address stepping, on and off
		u_rtw_host.wr(ADDR_CTRL, 8'ha0);
		u_rtw_host.wr(ADDR_RAM_ADDR, 8'h05);
		u_rtw_host.wr(ADDR_RAM_DATA, 8'h3c);
		`CK({o_ram_addr, o_ram_wdata}, 16'h063c)
		pk(ADDR_RAM_DATA, 8'h5a);
		`CK(o_ram_addr, 8'h07)
		u_rtw_host.wr(ADDR_CTRL, 8'h00);
		u_rtw_host.wr(ADDR_RAM_DATA, 8'h11);
		`CK(o_ram_addr, 8'h07)
		`CK(ram_wrs, 32'h2)
		i_oscillator_stop <= 1'b1;
		cyc(2);
		`CK(o_osc_run, 1'b0)
		i_oscillator_stop <= 1'b0;
		// Advance on: one update pulse per oscillator second, long wait
		u_rtw_host.wr(ADDR_CTRL, 8'h80);
		n = 0;
		while (o_update_tick !== 1'b1 && n < 70000)
		begin
			cyc(1);
			n++;
		end
		`CK(o_update_tick, 1'b1)
		cyc(1);
		`CK(o_update_tick, 1'b0)
		// Reset in mid-run
		u_rtw_host.wr(ADDR_CTRL, 8'h03);
		i_rst_b <= 1'b0;
		cyc(4);
		i_rst_b <= 1'b1;
		cyc(1);
		pk(ADDR_CTRL, 8'h00);
		conclude();
	end

	// Hang guard, well beyond the expected run
	initial
	begin
		#900000;
		failures++;
		conclude();
	end
endmodule
